// File: rtl/vram_xfer_ctrl.sv
// Functional notes
// R1: transfer-strobe low at row fall starts transfer
// R2: select level picks full or split
// R3: full read: transfer low, mask high, select low
// R4: row address picks copied row portions
// R5: column address becomes the tap
// R6: half flag follows column msb on full
// R7: realtime: raise transfer strobe with shift rise
// R8: early transfer-strobe rise means internal timing
// R9: split loads only the idle half
// R10: full read precedes any split read
// R11: split: select high, mask high, transfer low
// R12: split tap uses low eight column bits
// R13: half flag shows shifting half
// R14: half flag toggles at 255 or 511
// R15: upper split raises flag at 255th shift
// R16: full tap read before split tap
// R17: second split overwrites first before boundary
// R18: no split means wrap to zero
// R19: no split inside boundary forbidden window
// R20: split leaves serial direction unchanged
// R21: split copy timed internally
// R22: stop point valid after next split
// R23: stop-set size from row a7..a4
// R24: each shift rise advances serial counter
`timescale 1ns/10ps
`default_nettype none
`include "vram_xfer_consts.svh"

// small fifo with valid/ready on both sides
module xfer_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : xfer_fifo

// controller driving transfer cycles and shifting serial data out
module vram_xfer_ctrl
  import vram_xfer_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // user command port
  input wire cmd_t CMD,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [9:0] SHIFT_COUNT,
  // serial data to user
  output logic [15:0] DATA_OUT,
  output logic DATA_VALID,
  input wire logic DATA_READY,
  // device pins
  output pins_t PINS,
  input wire logic [15:0] SERIAL_DATA,
  input wire logic ACTIVE_HALF_FLAG,
  // status
  output logic HALF_FLAG_SEEN,
  output logic FULL_DONE,
  output logic ERROR_SPLIT
);
  typedef enum {ST_IDLE, ST_ROW, ST_COL, ST_HOLD, ST_END, ST_SHIFT_LO, ST_SHIFT_HI} st_t;
  st_t st_q;
  cmd_t cmd_q; // latched command
  logic [7:0] tmr_q; // strobe phase timer
  logic [9:0] shifts_q; // shifts left to run
  logic full_done_q; // full read seen since reset
  logic err_q; // split refused
  logic [15:0] sd_s1_q; // serial data sync
  logic [15:0] sd_s2_q;
  logic flag_s1_q; // half flag sync
  logic flag_s2_q;
  logic [15:0] fifo_in_q;
  logic fifo_in_v_q;
  logic [1:0] cap_q; // shift pulses waiting out the sync delay
  logic fifo_in_rdy;
  pins_t pins_q;
  logic tmr_done;
  logic split_refused;
  assign tmr_done = (tmr_q == 8'(`T_STROBE_CYC - 1));
  assign split_refused = (CMD.op == OP_SPLIT_READ) && !full_done_q; // R10
  assign CMD_READY = (st_q == ST_IDLE);
  assign PINS = pins_q;
  assign FULL_DONE = full_done_q;
  assign ERROR_SPLIT = err_q;
  assign HALF_FLAG_SEEN = flag_s2_q; // R13

  // input synchronisers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sd_s1_q <= 16'h0;
      sd_s2_q <= 16'h0;
      flag_s1_q <= 1'b0;
      flag_s2_q <= 1'b0;
    end else begin
      sd_s1_q <= SERIAL_DATA;
      sd_s2_q <= sd_s1_q;
      flag_s1_q <= ACTIVE_HALF_FLAG;
      flag_s2_q <= flag_s1_q;
    end
  end

  // sequencer for transfer, refresh option and shift phases
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_q <= ST_IDLE;
      cmd_q <= '0;
      tmr_q <= 8'h0;
      shifts_q <= 10'h0;
      full_done_q <= 1'b0;
      err_q <= 1'b0;
      pins_q <= '{ras_n: 1'b1, cas_n: 1'b1, transfer_or_output_strobe_n: 1'b1,
                 write_mask_strobe_n: 1'b1, special_function_select: 1'b0,
                 shift_out_gate_n: 1'b0, shift_clock: 1'b0, addr: 9'h0};
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (CMD_VALID && split_refused) begin
            err_q <= 1'b1; // R10
          end else if (CMD_VALID) begin
            cmd_q <= CMD;
            shifts_q <= SHIFT_COUNT;
            // shifts only follow the strobe cycle, so no split meets a boundary edge
            st_q <= ST_ROW; // R19
            pins_q.addr <= CMD.row; // R4
            // cas first for refresh options, else row strobe levels for transfer
            if (CMD.op == OP_STOP_SET || CMD.op == OP_OPTION_RESET) begin
              pins_q.cas_n <= 1'b0;
              pins_q.special_function_select <= (CMD.op == OP_STOP_SET);
              pins_q.write_mask_strobe_n <= (CMD.op != OP_STOP_SET); // R23
              pins_q.addr <= {CMD.row[8], CMD.row[7:4], 4'h0}; // R23
            end else begin
              pins_q.transfer_or_output_strobe_n <= 1'b0; // R1
              pins_q.write_mask_strobe_n <= 1'b1; // R3 R11
              pins_q.special_function_select <= (CMD.op == OP_SPLIT_READ); // R2 R3 R11
            end
            full_done_q <= full_done_q || (CMD.op inside {OP_FULL_READ, OP_REALTIME_READ});
          end
        end
        ST_ROW: begin
          // row strobe falls with levels already set up
          pins_q.ras_n <= 1'b0;
          tmr_q <= tmr_q + 8'h1;
          if (tmr_done) begin
            tmr_q <= 8'h0;
            if (cmd_q.op == OP_STOP_SET || cmd_q.op == OP_OPTION_RESET) begin
              st_q <= ST_HOLD; // R22
            end else begin
              st_q <= ST_COL;
              // full/split: release transfer strobe before column, internal timing
              pins_q.transfer_or_output_strobe_n <= (cmd_q.op != OP_REALTIME_READ); // R8 R21
              pins_q.addr <= (cmd_q.op == OP_SPLIT_READ) ?
                {1'b0, cmd_q.col[7:0]} : cmd_q.col; // R5 R6 R12
            end
          end
        end
        ST_COL: begin
          pins_q.cas_n <= 1'b0;
          tmr_q <= tmr_q + 8'h1;
          if (tmr_done) begin
            tmr_q <= 8'h0;
            st_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // realtime: raise transfer strobe with shift clock rise
          if (cmd_q.op == OP_REALTIME_READ) begin
            pins_q.transfer_or_output_strobe_n <= 1'b1; // R7
            pins_q.shift_clock <= 1'b1; // R7
          end
          st_q <= ST_END;
        end
        ST_END: begin
          pins_q.ras_n <= 1'b1;
          pins_q.cas_n <= 1'b1;
          pins_q.shift_clock <= 1'b0;
          pins_q.transfer_or_output_strobe_n <= 1'b1;
          pins_q.write_mask_strobe_n <= 1'b1;
          pins_q.special_function_select <= 1'b0;
          tmr_q <= tmr_q + 8'h1;
          if (tmr_done) begin
            tmr_q <= 8'h0;
            st_q <= (shifts_q != 10'h0) ? ST_SHIFT_LO : ST_IDLE;
          end
        end
        ST_SHIFT_LO: begin
          // each rise advances the device counter; wait till the last word has landed
          if (fifo_in_rdy && cap_q == 2'h0 && !fifo_in_v_q) begin
            pins_q.shift_clock <= 1'b1; // R24
            st_q <= ST_SHIFT_HI;
          end
        end
        ST_SHIFT_HI: begin
          pins_q.shift_clock <= 1'b0;
          shifts_q <= shifts_q - 10'h1;
          st_q <= (shifts_q == 10'h1) ? ST_IDLE : ST_SHIFT_LO;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // capture one serial word per shift pulse, three cycles after the rise (sync delay)
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      fifo_in_q <= 16'h0;
      fifo_in_v_q <= 1'b0;
      cap_q <= 2'h0;
    end else begin
      cap_q <= {cap_q[0], st_q == ST_SHIFT_HI}; // R24
      fifo_in_v_q <= cap_q[1];
      if (cap_q[1]) begin
        fifo_in_q <= sd_s2_q;
      end
    end
  end

  // serial data buffer
  xfer_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rstn(RSTN),
    .in_data(fifo_in_q),
    .in_valid(fifo_in_v_q),
    .in_ready(fifo_in_rdy),
    .out_data(DATA_OUT),
    .out_valid(DATA_VALID),
    .out_ready(DATA_READY)
  );

  // row strobe falls only with transfer strobe set up low for full and split transfers
  a_xfer_strobe_setup: assert property (@(posedge CLK) disable iff (!RSTN) // R1
    (st_q == ST_ROW && pins_q.ras_n && cmd_q.op inside {OP_FULL_READ, OP_SPLIT_READ})
    |-> !pins_q.transfer_or_output_strobe_n) else $error("transfer strobe high at row fall");
  a_split_select_high: assert property (@(posedge CLK) disable iff (!RSTN) // R11
    (st_q == ST_ROW && cmd_q.op == OP_SPLIT_READ) |-> pins_q.special_function_select &&
    pins_q.write_mask_strobe_n) else $error("split select levels wrong");
  a_full_select_low: assert property (@(posedge CLK) disable iff (!RSTN) // R3
    (st_q == ST_ROW && cmd_q.op == OP_FULL_READ) |-> !pins_q.special_function_select &&
    pins_q.write_mask_strobe_n) else $error("full select levels wrong");
  a_split_needs_full: assert property (@(posedge CLK) disable iff (!RSTN) // R10
    (st_q == ST_ROW && cmd_q.op == OP_SPLIT_READ) |-> full_done_q)
    else $error("split before full read");
  a_rt_strobe_sync: assert property (@(posedge CLK) disable iff (!RSTN) // R7
    (cmd_q.op == OP_REALTIME_READ && $rose(pins_q.transfer_or_output_strobe_n))
    |-> $rose(pins_q.shift_clock)) else $error("realtime rise not with shift");
  a_stop_set_levels: assert property (@(posedge CLK) disable iff (!RSTN) // R23
    (st_q == ST_ROW && cmd_q.op == OP_STOP_SET) |-> !pins_q.cas_n && !pins_q.write_mask_strobe_n
    && pins_q.special_function_select) else $error("stop set levels wrong");
  a_split_no_shift: assert property (@(posedge CLK) disable iff (!RSTN) // R19
    (cmd_q.op == OP_SPLIT_READ && !pins_q.ras_n) |-> !pins_q.shift_clock)
    else $error("shift edge during split cycle");
  a_fifo_no_drop: assert property (@(posedge CLK) disable iff (!RSTN) // R24
    fifo_in_v_q |-> fifo_in_rdy) else $error("captured word lost at full fifo");
endmodule : vram_xfer_ctrl
`default_nettype wire

// File: rtl/vram_xfer_consts.svh
`ifndef VRAM_XFER_CONSTS_SVH
`define VRAM_XFER_CONSTS_SVH
// serial memory geometry
`define SAM_WORDS 10'h200
`define SAM_HALF_LAST 9'h0ff
`define SAM_LAST 9'h1ff
`define SAM_HALF_BIT 8
// strobe timing, in ns and derived cycles at 5 ns
`define CLK_PERIOD_NS 5
`define T_STROBE_NS 20
`define T_STROBE_CYC ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// stop-set address patterns on a7..a4
`define STOP_1 4'hf
`define STOP_2 4'h7
`define STOP_4 4'h3
`define STOP_8 4'h1
`define STOP_16 4'h0
// fifo depth
`define FIFO_DEPTH 16
`endif

// File: rtl/vram_xfer_pkg.sv
package vram_xfer_pkg;
  // kinds of cycle the controller can run
  typedef enum logic [2:0] {
    OP_FULL_READ, OP_REALTIME_READ, OP_SPLIT_READ, OP_STOP_SET, OP_OPTION_RESET
  } op_t;
  // one user command
  typedef struct packed {
    op_t op;
    logic [8:0] row;
    logic [8:0] col;
  } cmd_t;
  // strobe pins toward the device
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic transfer_or_output_strobe_n;
    logic write_mask_strobe_n;
    logic special_function_select;
    logic shift_out_gate_n;
    logic shift_clock;
    logic [8:0] addr;
  } pins_t;
endpackage : vram_xfer_pkg

// File: tb/vram_device_model.sv
`timescale 1ns/10ps
`default_nettype none

// behavioural video memory: transfer decode, serial counter and half flag
module vram_device_model
  import vram_xfer_pkg::*;
(
  // strobes and address from the controller
  input wire pins_t PINS,
  // serial word and half flag back to the controller
  output logic [15:0] SERIAL_DATA,
  output logic ACTIVE_HALF_FLAG
);
  logic xfer_q = 1'b0; // a transfer cycle is open
  logic split_q = 1'b0; // the open cycle is a split one
  logic pend_q = 1'b0; // a split tap waits for the boundary
  logic [8:0] row_q = 9'h000; // row latched at the row strobe fall
  logic [8:0] ptr_q = 9'h000; // serial address counter
  logic [8:0] tap_q = 9'h000; // tap of the last split transfer
  logic [8:0] half_row_q [2] = '{9'h000, 9'h000}; // row copied into each half
  logic rt_q = 1'b0; // a real-time copy waits for its shift rise
  logic [8:0] rt_tap_q = 9'h000; // tap of the waiting real-time copy
  logic [3:0] stop_q = 4'hf; // active stop code, one stop point per half
  logic [3:0] stop_next_q = 4'hf; // stop code waiting for the next split

  initial SERIAL_DATA = 16'h0000;

  // row strobe fall: decode a transfer from the strobe levels
  always @(negedge PINS.ras_n) begin
    xfer_q = PINS.cas_n && !PINS.transfer_or_output_strobe_n && PINS.write_mask_strobe_n;
    split_q = PINS.special_function_select;
    row_q = PINS.addr;
    // column strobe already low: refresh with stop set or option reset
    if (!PINS.cas_n && PINS.special_function_select && !PINS.write_mask_strobe_n) begin
      stop_next_q = PINS.addr[7:4];
    end else if (!PINS.cas_n && !PINS.special_function_select) begin
      stop_next_q = 4'hf;
      stop_q = 4'hf;
    end
  end

  // column strobe fall: copy the row and set the tap, timed here
  always @(negedge PINS.cas_n) begin
    if (xfer_q && !split_q && !PINS.transfer_or_output_strobe_n) begin
      // strobe still low: the real-time copy waits for the paired shift rise
      rt_q = 1'b1;
      rt_tap_q = PINS.addr;
    end else if (xfer_q && !split_q) begin
      // full copy into both halves
      half_row_q[0] = row_q;
      half_row_q[1] = row_q;
      ptr_q = PINS.addr;
      pend_q = 1'b0;
    end else if (xfer_q) begin
      // only the idle half is loaded, the shifting half is untouched
      half_row_q[~ptr_q[8]] = row_q;
      tap_q = {~ptr_q[8], PINS.addr[7:0]};
      pend_q = 1'b1;
      stop_q = stop_next_q;
    end
    xfer_q = 1'b0;
  end

  // shift rise: present the word, then step or jump at a boundary
  always @(posedge PINS.shift_clock) begin
    if (rt_q && PINS.transfer_or_output_strobe_n) begin
      // strobe rise paired with this shift rise copies the row; no word leaves
      half_row_q[0] = row_q;
      half_row_q[1] = row_q;
      ptr_q = rt_tap_q;
      pend_q = 1'b0;
      rt_q = 1'b0;
    end else begin
      SERIAL_DATA = {half_row_q[ptr_q[8]][6:0], ptr_q};
      if ((ptr_q[7:4] & stop_q) == stop_q && ptr_q[3:0] == 4'hf && pend_q) begin
        ptr_q = tap_q;
        pend_q = 1'b0;
      end else begin
        ptr_q = ptr_q + 9'h001;
      end
    end
  end

  // half flag follows the half the counter points into
  assign ACTIVE_HALF_FLAG = ptr_q[8];
endmodule : vram_device_model

`default_nettype wire

// File: tb/vram_ram_to_serial_transfer_bench.sv
`timescale 1ns/10ps
`default_nettype none

// self-checking bench for the transfer controller
module vram_ram_to_serial_transfer_bench
  import vram_xfer_pkg::*;
;
  logic CLK, RSTN, CMD_VALID, CMD_READY, DATA_VALID, ACTIVE_HALF_FLAG; // handshakes
  logic DATA_READY = 1'b0; // drain side of the fifo
  logic HALF_FLAG_SEEN, FULL_DONE, ERROR_SPLIT; // status
  logic [9:0] SHIFT_COUNT; // shifts after a cycle
  logic [15:0] DATA_OUT, SERIAL_DATA; // words
  cmd_t CMD; // user command
  pins_t PINS; // device pins
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] seed_q = 32'd63985; // random state
  logic [8:0] e_row [2]; // expected row in each half
  logic [8:0] e_ptr, e_tap; // expected counter and split tap
  logic e_pend, full_seen; // split pending, a full read done
  logic [15:0] exp_q [$]; // expected words in order
  op_t ops [3] = '{OP_FULL_READ, OP_REALTIME_READ, OP_SPLIT_READ};

  vram_xfer_ctrl vram_xfer_ctrl_inst (.CLK(CLK), .RSTN(RSTN), .CMD(CMD),
    .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .SHIFT_COUNT(SHIFT_COUNT),
    .DATA_OUT(DATA_OUT), .DATA_VALID(DATA_VALID), .DATA_READY(DATA_READY), .PINS(PINS),
    .SERIAL_DATA(SERIAL_DATA), .ACTIVE_HALF_FLAG(ACTIVE_HALF_FLAG),
    .HALF_FLAG_SEEN(HALF_FLAG_SEEN), .FULL_DONE(FULL_DONE), .ERROR_SPLIT(ERROR_SPLIT));
  vram_device_model vram_device_model_inst (.PINS(PINS), .SERIAL_DATA(SERIAL_DATA),
    .ACTIVE_HALF_FLAG(ACTIVE_HALF_FLAG));

  // xorshift source
  function automatic logic [31:0] xs();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q;
  endfunction : xs

  // word comparison
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  // flag comparison
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  // verdict and end of run
  task complete_run;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // predict the words, issue one command, wait till idle and drained
  task automatic run(input op_t op, input logic [8:0] row, input logic [8:0] col,
      input logic [9:0] n);
    int i;
    if (op != OP_SPLIT_READ || full_seen) begin
      if (op == OP_FULL_READ || op == OP_REALTIME_READ) begin
        // full copy sets tap and half
        e_row[0] = row;
        e_row[1] = row;
        e_ptr = col;
        e_pend = 1'b0;
        full_seen = 1'b1;
      end else if (op == OP_SPLIT_READ) begin
        // split fills the idle half, tap waits for the boundary
        e_row[~e_ptr[8]] = row;
        e_tap = {~e_ptr[8], col[7:0]};
        e_pend = 1'b1;
      end
      for (i = 0; i < n; i++) begin
        exp_q.push_back({e_row[e_ptr[8]][6:0], e_ptr});
        if (e_ptr[7:0] == 8'hff && e_pend) begin
          e_ptr = e_tap;
          e_pend = 1'b0;
        end else e_ptr = e_ptr + 9'h001;
      end
    end
    @(negedge CLK);
    CMD = '{op, row, col};
    SHIFT_COUNT = n;
    CMD_VALID = 1'b1;
    for (i = 0; i < 50 && CMD_READY !== 1'b1; i++) @(negedge CLK);
    @(posedge CLK);
    @(negedge CLK);
    CMD_VALID = 1'b0;
    for (i = 0; i < 20000 && (CMD_READY !== 1'b1 || exp_q.size() != 0); i++) @(negedge CLK);
    repeat (8) @(negedge CLK);
    chk_bit(HALF_FLAG_SEEN, e_ptr[8]);
  endtask : run

  // clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // random drain at the falling edge
  always @(negedge CLK) DATA_READY <= RSTN && ((xs() & 32'h1) != 0);

  // every word leaving the fifo is compared in order
  always @(posedge CLK) begin
    if (RSTN && DATA_VALID === 1'b1 && DATA_READY) begin
      chk_word(DATA_OUT, exp_q.size() != 0 ? exp_q.pop_front() : 16'hdead);
    end
  end

  // hang guard
  initial begin
    #300000;
    n_mismatch++;
    complete_run;
  end

  // main sequence
  initial begin
    logic [31:0] r;
    int k;
    RSTN = 1'b0;
    CMD = '0;
    CMD_VALID = 1'b0;
    SHIFT_COUNT = 10'h000;
    e_ptr = 9'h000;
    e_tap = 9'h000;
    e_pend = 1'b0;
    full_seen = 1'b0;
    repeat (6) @(posedge CLK);
    @(negedge CLK);
    RSTN = 1'b1;
    run(OP_SPLIT_READ, 9'h011, 9'h022, 10'h000);
    chk_bit(ERROR_SPLIT, 1'b1);
    chk_bit(FULL_DONE, 1'b0);
    run(OP_FULL_READ, 9'h0a5, 9'h1f0, 10'h014);
    chk_bit(FULL_DONE, 1'b1);
    run(OP_FULL_READ, 9'h033, 9'h0f8, 10'h003);
    run(OP_SPLIT_READ, 9'h044, 9'h110, 10'h000);
    run(OP_SPLIT_READ, 9'h055, 9'h120, 10'h00a);
    run(OP_STOP_SET, 9'h070, 9'h000, 10'h000);
    run(OP_OPTION_RESET, 9'h000, 9'h000, 10'h000);
    run(OP_REALTIME_READ, 9'h066, 9'h100, 10'h005);
    for (k = 0; k < 14; k++) begin
      r = xs();
      run(ops[r % 3], r[12:4], r[21:13], {4'h0, r[27:22]});
    end
    chk_word(16'(exp_q.size()), 16'h0000);
    complete_run;
  end
endmodule : vram_ram_to_serial_transfer_bench

`default_nettype wire
